// ==== core/module_power_control.sv ====
// Purpose: module power sequencing, power loss policy and fan control
// Assumes: pins other than standbyPresent pass two flip-flops; persist record held in always-on storage
// Notes: standby monitoring window is timed by a slow tick from a divider
`timescale 1ns/1ps
// Contract
// - hold module reset while power-good low
// - power-good high permits onboard sequencing
// - floating power-good reads as released
// - supply-on request driven active low
// - button low requests power toggle
// - deep sleep answers only limited wakes
// - deep sleep wake returns to entry state
// - standby stable thirty seconds means clean off
// - standby lost within window means AC loss
// - standby return applies selected restore policy
// - monitoring only under last-state policy
// - early loss may record last state on
// - no standby rail disables restore policy
// - fan speed by pulse width modulation
// - rpm from two tach pulses per revolution
// - enhanced soft-off keeps only exit logic
module module_power_control #(
  parameter int unsigned WINDOW_TICKS = power_control_pkg::STBY_WINDOW_TICKS,
  parameter int unsigned TICK_CYCLES = power_control_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // carrier pins
  input wire logic powerGoodInput,
  input wire logic powerButton_n,
  input wire logic standbyRail,
  input wire logic standbyPresent,
  input wire logic fanSpeedPulseIn,
  output logic supplyOnRequest_n,
  output logic moduleReset_n,
  output logic fanDrivePwm,
  // configuration and host requests
  input wire logic [1:0] restorePolicy,
  input wire logic [7:0] fanDuty,
  input wire power_control_pkg::host_req_t hostReq,
  // persistent record
  input wire power_control_pkg::persist_t persistIn,
  output power_control_pkg::persist_t persistOut,
  output logic persistWrite,
  // status
  output power_control_pkg::pwr_state_t powerState,
  output logic [1:0] sleepEntry,
  output logic monitoring,
  output logic [15:0] fanRpm
);

  initial begin
    if (WINDOW_TICKS < 2 || TICK_CYCLES < 2) $error("module_power_control: counts too small");
  end

  // ==========================================
  // pin synchronisers
  logic [3:0] syncA_reg, syncB_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      // pulled-up pins idle high, the tach pin idles low: no false edge after reset
      syncA_reg <= 4'hE;
      syncB_reg <= 4'hE;
    end else begin
      syncA_reg <= {powerGoodInput, powerButton_n, standbyRail, fanSpeedPulseIn};
      syncB_reg <= syncA_reg;
    end
  end
  // the pin sees a pulled-up level when floated, so float counts as released
  logic pgood, btn_n, stby, tach;
  assign pgood = syncB_reg[3];
  assign btn_n = syncB_reg[2];
  assign stby = syncB_reg[1];
  assign tach = syncB_reg[0];

  // ==========================================
  // timebase divider
  logic [31:0] div_reg, div_next;
  logic tick;
  always_comb begin
    div_next = (div_reg == TICK_CYCLES - 1) ? 32'h00000000 : div_reg + 32'h00000001;
  end
  assign tick = (div_reg == TICK_CYCLES - 1);
  always_ff @(posedge clk) begin
    if (rst) div_reg <= 32'h00000000;
    else div_reg <= div_next;
  end

  // ==========================================
  // power state machine
  power_control_pkg::pwr_state_t st_reg, st_next;
  logic [1:0] entry_reg, entry_next;
  logic btnPrev_reg, btnPrev_next;
  logic mon_reg, mon_next;
  logic [31:0] win_reg, win_next;
  logic restored_reg, restored_next;
  power_control_pkg::persist_t rec_reg, rec_next;
  logic pwrite_next, pwrite_reg;
  logic btnPress;

  assign btnPress = !btn_n && btnPrev_reg;

  always_comb begin
    st_next = st_reg;
    entry_next = entry_reg;
    btnPrev_next = btn_n;
    mon_next = mon_reg;
    win_next = win_reg;
    restored_next = restored_reg;
    rec_next = rec_reg;
    pwrite_next = 1'b0;
    // power-loss policy once, in the first cycle after reset, only if standby is present then
    if (!restored_reg) begin
      restored_next = 1'b1;
      rec_next = persistIn;
      if (standbyPresent && pgood) begin
        case (restorePolicy)
          power_control_pkg::POLICY_TURN_ON: st_next = power_control_pkg::PWR_SEQ;
          power_control_pkg::POLICY_LAST_STATE: begin
            if (persistIn.lastOn) st_next = power_control_pkg::PWR_SEQ;
          end
          default: st_next = power_control_pkg::PWR_OFF;
        endcase
      end
    end else begin
      case (st_reg)
        power_control_pkg::PWR_OFF: begin
          // the supply must come up before power-good can rise, so the press alone starts it
          if (btnPress) st_next = power_control_pkg::PWR_SEQ;
        end
        power_control_pkg::PWR_SEQ: begin
          if (pgood) begin
            st_next = power_control_pkg::PWR_ON;
            rec_next.lastOn = 1'b1;
            pwrite_next = 1'b1;
          end
        end
        power_control_pkg::PWR_ON: begin
          if (hostReq.shutdownReq || btnPress) begin
            st_next = power_control_pkg::PWR_OFF;
            entry_next = power_control_pkg::SLEEP_S5;
            if (restorePolicy == power_control_pkg::POLICY_LAST_STATE && standbyPresent) begin
              mon_next = 1'b1;
              win_next = 32'h00000000;
            end
          end else if (hostReq.sleepReq) begin
            st_next = hostReq.deepReq ? power_control_pkg::PWR_DEEP : power_control_pkg::PWR_SLEEP;
            entry_next = hostReq.sleepKind;
          end else if (hostReq.enhOffReq) begin
            st_next = power_control_pkg::PWR_SOFTOFF_E;
            entry_next = power_control_pkg::SLEEP_S5;
          end
        end
        power_control_pkg::PWR_SLEEP: begin
          if (hostReq.deepReq) st_next = power_control_pkg::PWR_DEEP;
          else if (btnPress || hostReq.wakeEvent) st_next = power_control_pkg::PWR_SEQ;
        end
        power_control_pkg::PWR_DEEP: begin
          // only button and the wake line are heard here
          if (btnPress || hostReq.wakeEvent) begin
            st_next = (entry_reg == power_control_pkg::SLEEP_S3) ? power_control_pkg::PWR_SLEEP
                                                                 : power_control_pkg::PWR_OFF;
          end
        end
        power_control_pkg::PWR_SOFTOFF_E: begin
          if (btnPress) st_next = power_control_pkg::PWR_SEQ;
        end
        default: st_next = power_control_pkg::PWR_OFF;
      endcase
      // standby monitoring window
      if (mon_reg) begin
        if (!stby) begin
          // loss inside the window leaves lastOn as it was, which may still read on
          mon_next = 1'b0;
          rec_next.acLoss = 1'b1;
          rec_next.cleanOff = 1'b0;
          pwrite_next = 1'b1;
        end else if (tick) begin
          if (win_reg == WINDOW_TICKS - 1) begin
            mon_next = 1'b0;
            rec_next.cleanOff = 1'b1;
            rec_next.acLoss = 1'b0;
            rec_next.lastOn = 1'b0;
            pwrite_next = 1'b1;
          end else begin
            win_next = win_reg + 32'h00000001;
          end
        end
      end
    end
    // power-good lost while on: back to sequencing with the module held in reset
    // sleep states keep their state, as power-good drops there with the main supply
    if (!pgood && st_next == power_control_pkg::PWR_ON) st_next = power_control_pkg::PWR_SEQ;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= power_control_pkg::PWR_OFF;
      entry_reg <= power_control_pkg::SLEEP_S5;
      btnPrev_reg <= 1'b1;
      mon_reg <= 1'b0;
      win_reg <= 32'h00000000;
      restored_reg <= 1'b0;
      rec_reg <= '0;
      pwrite_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      entry_reg <= entry_next;
      btnPrev_reg <= btnPrev_next;
      mon_reg <= mon_next;
      win_reg <= win_next;
      restored_reg <= restored_next;
      rec_reg <= rec_next;
      pwrite_reg <= pwrite_next;
    end
  end

  // ==========================================
  // outputs
  logic reset_n_reg, supply_n_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      reset_n_reg <= 1'b0;
      supply_n_reg <= 1'b1;
    end else begin
      reset_n_reg <= pgood && (st_next == power_control_pkg::PWR_ON);
      supply_n_reg <= !(st_next == power_control_pkg::PWR_SEQ || st_next == power_control_pkg::PWR_ON);
    end
  end

  assign moduleReset_n = reset_n_reg;
  assign supplyOnRequest_n = supply_n_reg;
  assign persistOut = rec_reg;
  assign persistWrite = pwrite_reg;
  assign powerState = st_reg;
  assign sleepEntry = entry_reg;
  assign monitoring = mon_reg;

  fan_control #(.PWM_BITS(8), .RPM_BITS(16)) fan (
    .clk(clk),
    .rst(rst),
    .tick(tick),
    .duty(fanDuty),
    .tachSync(tach),
    .fanPwm(fanDrivePwm),
    .rpm(fanRpm)
  );

  // ==========================================
  // checks
  reset_hold_a: assert property (@(posedge clk) disable iff (rst) !pgood |=> !moduleReset_n)
    else $error("module left reset while power-good low");
  supply_on_a: assert property (@(posedge clk) disable iff (rst)
    (powerState == power_control_pkg::PWR_ON) |-> !supplyOnRequest_n)
    else $error("supply request high while on");
  seq_gate_a: assert property (@(posedge clk) disable iff (rst)
    (powerState == power_control_pkg::PWR_SEQ && !pgood) |=> powerState != power_control_pkg::PWR_ON)
    else $error("sequencing advanced without power-good");
  deep_wake_a: assert property (@(posedge clk) disable iff (rst)
    (powerState == power_control_pkg::PWR_DEEP && !btnPress && !hostReq.wakeEvent && pgood)
    |=> powerState == power_control_pkg::PWR_DEEP)
    else $error("deep sleep left without wake event");
  deep_resume_a: assert property (@(posedge clk) disable iff (rst)
    (powerState == power_control_pkg::PWR_DEEP && sleepEntry == power_control_pkg::SLEEP_S3 && pgood
     && (btnPress || hostReq.wakeEvent)) |=> powerState == power_control_pkg::PWR_SLEEP)
    else $error("deep sleep did not resume to entry state");
  ac_loss_a: assert property (@(posedge clk) disable iff (rst)
    (monitoring && !stby) |=> (!monitoring && persistOut.acLoss && persistWrite))
    else $error("standby loss not classified as power loss");
  mon_policy_a: assert property (@(posedge clk) disable iff (rst)
    $rose(monitoring) |-> restorePolicy == power_control_pkg::POLICY_LAST_STATE)
    else $error("monitoring outside last-state policy");
  no_stby_a: assert property (@(posedge clk) disable iff (rst)
    (!restored_reg && !standbyPresent) |=> powerState == power_control_pkg::PWR_OFF)
    else $error("restore policy acted without standby");
  win_restart_a: assert property (@(posedge clk) disable iff (rst)
    $rose(monitoring) |-> win_reg == 32'h00000000)
    else $error("window counter not restarted");

endmodule : module_power_control

// ==== common/power_control_pkg.sv ====
// Purpose: shared constants and types for the module power controller
// Assumes: 125 MHz system clock, one clock domain
// Notes: times are kept in their own unit, cycle counts derive from them
package power_control_pkg;

  localparam int unsigned CLK_HZ = 125000000;
  // standby monitoring window, seconds
  localparam int unsigned STBY_WINDOW_S = 30;
  // slow timebase tick period, microseconds
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYCLES = (CLK_HZ / 1000000) * TICK_US;
  // window length in ticks (ms)
  localparam int unsigned STBY_WINDOW_TICKS = STBY_WINDOW_S * (1000000 / TICK_US);
  // tach pulses per revolution
  localparam int unsigned TACH_PULSES_PER_REV = 2;
  // rpm gate: one second of ticks, rpm = pulses * 60 / pulses per rev
  localparam int unsigned RPM_GATE_TICKS = 1000000 / TICK_US;
  localparam int unsigned RPM_SCALE = 60 / TACH_PULSES_PER_REV;

  // restore policy encodings
  localparam logic [1:0] POLICY_REMAIN_OFF = 2'h0;
  localparam logic [1:0] POLICY_TURN_ON = 2'h1;
  localparam logic [1:0] POLICY_LAST_STATE = 2'h2;

  // sleep state encodings
  localparam logic [1:0] SLEEP_S3 = 2'h0;
  localparam logic [1:0] SLEEP_S4 = 2'h1;
  localparam logic [1:0] SLEEP_S5 = 2'h2;

  typedef enum logic [2:0] {
    PWR_OFF = 3'h0,
    PWR_SEQ = 3'h1,
    PWR_ON = 3'h2,
    PWR_SLEEP = 3'h3,
    PWR_DEEP = 3'h4,
    PWR_SOFTOFF_E = 3'h5
  } pwr_state_t;

  // persistent record kept in always-on storage
  typedef struct packed {
    logic lastOn;
    logic acLoss;
    logic cleanOff;
  } persist_t;

  // host side requests
  typedef struct packed {
    logic sleepReq;
    logic [1:0] sleepKind;
    logic deepReq;
    logic enhOffReq;
    logic shutdownReq;
    logic wakeEvent;
  } host_req_t;

endpackage : power_control_pkg

// ==== core/fan_control.sv ====
// Purpose: fan pwm drive and tach based rpm measurement
// Assumes: tach input already synchronised; tick is a one-cycle enable
// Notes: rpm assumes two tach pulses per revolution
`timescale 1ns/1ps
module fan_control #(
  parameter int unsigned PWM_BITS = 8,
  parameter int unsigned RPM_BITS = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic tick,
  input wire logic [PWM_BITS-1:0] duty,
  input wire logic tachSync,
  // outputs
  output logic fanPwm,
  output logic [RPM_BITS-1:0] rpm
);

  initial begin
    if (PWM_BITS < 2 || RPM_BITS < 8) $error("fan_control: width too small");
  end

  logic [PWM_BITS-1:0] phase_reg, phase_next;
  logic pwm_reg, pwm_next;
  logic tachPrev_reg, tachPrev_next;
  logic [RPM_BITS-1:0] pulses_reg, pulses_next;
  logic [RPM_BITS-1:0] rpm_reg, rpm_next;
  logic [15:0] gate_reg, gate_next;

  // ==========================================
  // pwm and tach counting
  always_comb begin
    phase_next = phase_reg + 1'b1;
    pwm_next = (phase_reg < duty);
    tachPrev_next = tachSync;
    pulses_next = pulses_reg;
    rpm_next = rpm_reg;
    gate_next = gate_reg;
    if (tachSync && !tachPrev_reg) begin
      pulses_next = pulses_reg + 1'b1;
    end
    if (tick) begin
      if (gate_reg == 16'(power_control_pkg::RPM_GATE_TICKS - 1)) begin
        gate_next = 16'h0000;
        rpm_next = RPM_BITS'(pulses_next * power_control_pkg::RPM_SCALE);
        pulses_next = '0;
      end else begin
        gate_next = gate_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      phase_reg <= '0;
      pwm_reg <= 1'b0;
      tachPrev_reg <= 1'b0;
      pulses_reg <= '0;
      rpm_reg <= '0;
      gate_reg <= 16'h0000;
    end else begin
      phase_reg <= phase_next;
      pwm_reg <= pwm_next;
      tachPrev_reg <= tachPrev_next;
      pulses_reg <= pulses_next;
      rpm_reg <= rpm_next;
      gate_reg <= gate_next;
    end
  end

  assign fanPwm = pwm_reg;
  assign rpm = rpm_reg;

  fan_off_a: assert property (@(posedge clk) disable iff (rst) (duty == '0) |=> !fanPwm)
    else $error("fan drive high with zero duty");

endmodule : fan_control

// ==== tb/carrier_model.sv ====
// Purpose: carrier power circuitry, button and fan tach model
// Assumes: one clock; power-good is pulled up on the module side
// Notes: power-good is pulled low while held and for PG_DELAY cycles after release, then driven high, never left floating
`timescale 1ns/1ps
module carrier_model #(
  parameter int unsigned PG_DELAY = 8
) (
  // clock
  input wire logic clk,
  // bench controls
  input wire logic holdPg,
  input wire logic railOn,
  input wire logic press,
  input wire logic spin,
  // block pins
  input wire logic supplyOnRequest_n,
  output logic powerGoodInput,
  output logic standbyRail,
  output logic powerButton_n,
  output logic fanSpeedPulseIn,
  output logic mainOn
);
  int pgCnt = 0;
  int tachCnt = 0;
  logic tachLvl = 1'b0;
  // ==========================================
  // release only after rails have settled
  always @(posedge clk) begin
    pgCnt <= holdPg ? 0 : (pgCnt < PG_DELAY ? pgCnt + 1 : pgCnt);
    tachCnt <= (tachCnt == 19) ? 0 : tachCnt + 1;
    if (spin && tachCnt == 19) begin
      tachLvl <= !tachLvl;
    end
  end
  // released pin is driven high, standing in for the pull-up
  assign powerGoodInput = (pgCnt < PG_DELAY) ? 1'b0 : 1'b1;
  assign mainOn = !supplyOnRequest_n;
  assign standbyRail = railOn;
  assign fanSpeedPulseIn = tachLvl;
  assign powerButton_n = !press;
endmodule : carrier_model

// ==== tb/module_power_control_tb.sv ====
// Purpose: self-checking bench for the module power controller
// Assumes: short window and tick parameters, inputs driven at falling edge
// Notes: tach period 40 cycles, rpm gate 4000 cycles
`timescale 1ns/1ps
module module_power_control_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic holdPg = 1'b1;
  logic railOn = 1'b1;
  logic press = 1'b0;
  logic spin = 1'b0;
  logic standbyPresent = 1'b1;
  logic [1:0] restorePolicy = 2'h0;
  logic [7:0] fanDuty = 8'h00;
  power_control_pkg::host_req_t hostReq = '0;
  power_control_pkg::persist_t persistIn = '0;
  power_control_pkg::persist_t persistOut;
  power_control_pkg::pwr_state_t powerState;
  logic powerGoodInput, powerButton_n, standbyRail, fanSpeedPulseIn, mainOn;
  logic supplyOnRequest_n, moduleReset_n, fanDrivePwm, persistWrite, monitoring;
  logic [1:0] sleepEntry;
  logic [15:0] fanRpm;
  int miscompares = 0;
  int samples_checked = 0;

  carrier_model i_carrier (.clk(clk), .holdPg(holdPg), .railOn(railOn), .press(press), .spin(spin),
    .supplyOnRequest_n(supplyOnRequest_n), .powerGoodInput(powerGoodInput), .standbyRail(standbyRail),
    .powerButton_n(powerButton_n), .fanSpeedPulseIn(fanSpeedPulseIn), .mainOn(mainOn));
  module_power_control #(.WINDOW_TICKS(4), .TICK_CYCLES(4)) i_dut (.clk(clk), .rst(rst),
    .powerGoodInput(powerGoodInput), .powerButton_n(powerButton_n), .standbyRail(standbyRail),
    .standbyPresent(standbyPresent), .fanSpeedPulseIn(fanSpeedPulseIn), .supplyOnRequest_n(supplyOnRequest_n),
    .moduleReset_n(moduleReset_n), .fanDrivePwm(fanDrivePwm), .restorePolicy(restorePolicy),
    .fanDuty(fanDuty), .hostReq(hostReq), .persistIn(persistIn), .persistOut(persistOut),
    .persistWrite(persistWrite), .powerState(powerState), .sleepEntry(sleepEntry),
    .monitoring(monitoring), .fanRpm(fanRpm));

  initial begin
    forever #4 clk = ~clk;
  end

  // ==========================================
  // helpers
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chkState(input string what, input power_control_pkg::pwr_state_t exp);
    chk(what, 16'(exp), 16'(powerState));
  endtask : chkState

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task automatic doReset(input logic [1:0] pol, input logic [2:0] rec);
    restorePolicy = pol;
    persistIn = rec;
    rst = 1'b1;
    cyc(6);
    rst = 1'b0;
    cyc(20);
  endtask : doReset

  task automatic req(input power_control_pkg::host_req_t r);
    hostReq = r;
    cyc(1);
    hostReq = '0;
    cyc(4);
  endtask : req

  // wait for a persist write carrying the given record bits
  task automatic waitRec(input string what, input logic [2:0] mask, input int lim);
    int i;
    for (i = 0; i < lim && !(persistWrite === 1'b1 && (persistOut & mask) === mask); i++) cyc(1);
    chk(what, 16'h1, 16'(i < lim));
  endtask : waitRec

  task automatic powerUp();
    holdPg = 1'b1;
    cyc(2);
    press = 1'b1;
    cyc(4);
    press = 1'b0;
    cyc(6);
    chkState("held in sequencing", power_control_pkg::PWR_SEQ);
    chk("module reset held", 16'h0, 16'(moduleReset_n));
    chk("supply request", 16'h0, 16'(supplyOnRequest_n));
    holdPg = 1'b0;
    cyc(20);
    chkState("powered on", power_control_pkg::PWR_ON);
    chk("module reset free", 16'h1, 16'(moduleReset_n));
    chk("main supply", 16'h1, 16'(mainOn));
  endtask : powerUp

  // ==========================================
  // scenarios
  task automatic testPowerUp();
    doReset(power_control_pkg::POLICY_REMAIN_OFF, 3'h0);
    chkState("reset state", power_control_pkg::PWR_OFF);
    chk("reset supply", 16'h1, 16'(supplyOnRequest_n));
    chk("reset pwm", 16'h0, 16'(fanDrivePwm));
    powerUp();
    $display("test power up done");
  endtask : testPowerUp

  task automatic testWindow();
    restorePolicy = power_control_pkg::POLICY_LAST_STATE;
    req(7'h02);
    chk("monitoring", 16'h1, 16'(monitoring));
    waitRec("clean off", 3'h1, 200);
    powerUp();
    req(7'h02);
    railOn = 1'b0;
    waitRec("ac loss with last on", 3'h6, 40);
    railOn = 1'b1;
    cyc(5);
    restorePolicy = power_control_pkg::POLICY_TURN_ON;
    powerUp();
    req(7'h02);
    chk("no monitoring", 16'h0, 16'(monitoring));
    $display("test window done");
  endtask : testWindow

  task automatic testPolicy();
    logic [1:0] pol [6] = '{2'h1, 2'h0, 2'h2, 2'h2, 2'h1, 2'h3};
    logic [2:0] rec [6] = '{3'h2, 3'h6, 3'h6, 3'h2, 3'h2, 3'h6};
    logic pres [6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
    logic on [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    holdPg = 1'b0;
    for (int k = 0; k < 6; k++) begin
      standbyPresent = pres[k];
      doReset(pol[k], rec[k]);
      chkState("restored", on[k] ? power_control_pkg::PWR_ON : power_control_pkg::PWR_OFF);
    end
    standbyPresent = 1'b1;
    $display("test policy done");
  endtask : testPolicy

  task automatic testSleep();
    doReset(power_control_pkg::POLICY_REMAIN_OFF, 3'h0);
    powerUp();
    req(7'h40);
    chkState("sleep", power_control_pkg::PWR_SLEEP);
    chk("entry", 16'(power_control_pkg::SLEEP_S3), 16'(sleepEntry));
    req(7'h08);
    chkState("deep", power_control_pkg::PWR_DEEP);
    req(7'h02);
    chkState("deep ignores shutdown", power_control_pkg::PWR_DEEP);
    req(7'h01);
    chkState("resumed", power_control_pkg::PWR_SLEEP);
    doReset(power_control_pkg::POLICY_REMAIN_OFF, 3'h0);
    powerUp();
    req(7'h42);
    chkState("shutdown first", power_control_pkg::PWR_OFF);
    powerUp();
    req(7'h58);
    chkState("deep from s4", power_control_pkg::PWR_DEEP);
    chk("entry s4", 16'(power_control_pkg::SLEEP_S4), 16'(sleepEntry));
    req(7'h01);
    chkState("resumed to off", power_control_pkg::PWR_OFF);
    powerUp();
    req(7'h04);
    chkState("enhanced off", power_control_pkg::PWR_SOFTOFF_E);
    chk("enhanced supply", 16'h1, 16'(supplyOnRequest_n));
    $display("test sleep done");
  endtask : testSleep

  task automatic testFan();
    int hi;
    powerUp();
    fanDuty = 8'h40;
    spin = 1'b1;
    cyc(4);
    hi = 0;
    repeat (256) begin
      cyc(1);
      hi += fanDrivePwm ? 1 : 0;
    end
    chk("pwm high count", 16'h0040, 16'(hi));
    cyc(8200);
    chk("rpm in range", 16'h1, 16'(fanRpm >= 16'd2970 && fanRpm <= 16'd3030));
    $display("test fan done");
  endtask : testFan

  initial begin
    testPowerUp();
    testWindow();
    testPolicy();
    testSleep();
    testFan();
    summarize();
  end

  initial begin
    #(8 * 60000);
    miscompares++;
    $display("watchdog expired");
    summarize();
  end
endmodule : module_power_control_tb
